// [hw/compat_pkg.sv]
// Constants, register map and carrier types for the legacy compatibility block.
// Assumes a single 250 MHz clock domain and an APB master with 32-bit data.
package compat_pkg;

	// Clock and reset figures
	localparam int CLK_PERIOD_PS = 4000;
	localparam int RESET_MIN_PULSE_NS = 2500; // board must hold reset low this long
	localparam int WDT_UNLOCK_NS = 16;
	localparam int WDT_UNLOCK_CYCLES = (WDT_UNLOCK_NS * 1000) / CLK_PERIOD_PS;

	// Port geometry: four 8-bit ports and one 3-bit port
	localparam int NUM_PORTS = 5;
	localparam int PORT_MAX_W = 8;
	localparam int PORT_E_W = 3;
	localparam int PIN_COUNT = 35;
	localparam int JTAG_PORT = 2;
	localparam logic [7:0] JTAG_PULL_MASK = 8'hB0; // data in, mode select, test clock

	// Data space map of the core
	localparam logic [15:0] EXT_IO_LO = 16'h0060;
	localparam logic [15:0] EXT_IO_HI = 16'h00FF;
	localparam logic [15:0] TIMER2_LO = 16'h0080;
	localparam logic [15:0] TIMER2_HI = 16'h008B;

	// Interrupt vector table sizes (arbitrary plain values)
	localparam int VEC_LEGACY = 20;
	localparam int VEC_EXTENDED = 28;
	localparam int VEC_W = 5;

	// APB register byte addresses
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_WDT = 12'h004;
	localparam logic [11:0] ADDR_BAUD0 = 12'h008;
	localparam logic [11:0] ADDR_BAUD1 = 12'h00C;
	localparam logic [11:0] ADDR_RX_DATA = 12'h010;
	localparam logic [11:0] ADDR_RX_STAT = 12'h014;
	localparam logic [11:0] ADDR_PC_MASK = 12'h018;
	localparam logic [11:0] ADDR_PORT_BASE = 12'h020;
	localparam logic [11:0] ADDR_PORT_END = 12'h06F;
	localparam logic [3:0] PORT_DIR_OFS = 4'h0;
	localparam logic [3:0] PORT_OUT_OFS = 4'h4;
	localparam logic [3:0] PORT_IN_OFS = 4'h8;

	// Field positions
	localparam int WDT_PERIOD_W = 3;
	localparam int WDT_CHANGE_BIT = 4;
	localparam int BAUD_HIGH_W = 4;
	localparam int RX_AVAIL_BIT = 0;
	localparam int RX_FULL_BIT = 1;
	localparam int RX_OVERRUN_BIT = 2;

	// Reset values
	localparam logic [2:0] WDT_PERIOD_RST = 3'h0;
	localparam logic [3:0] BAUD_HIGH_RST = 4'h0;
	localparam logic [7:0] PORT_RST = 8'h00;

	// Feature set that follows the compatibility fuse
	typedef struct packed {
		logic ext_vectors;
		logic timer2;
		logic pin_change;
		logic rx_double;
		logic wdt_timed;
		logic ext_io;
	} feature_t;

	// Receive byte with its strobe
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rx_byte_t;

	typedef logic [PIN_COUNT-1:0] pins_t;

endpackage : compat_pkg

// [hw/port_bank.sv]
// One general I/O port: direction, drive, pull-up and input sampling.
// Assumes dir and out come from flip-flops cleared by the device reset.
`timescale 1ns/10ps
module port_bank #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic rst_n,
	// Control from the register file and the JTAG fuse
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] pull_force,
	// Pad
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] pin_o,
	output logic [W-1:0] pin_oe,
	output logic [W-1:0] pull_en,
	// Sampled pin level
	output logic [W-1:0] pin_val
);

	// Drivers off at once while reset is low, clock or no clock
	assign pin_oe = dir & {W{rst_n}};
	assign pin_o = out;

	// Per-bit pull-up on inputs, forced ones survive reset
	assign pull_en = (~dir & out & {W{rst_n}}) | pull_force;

	// Input sampling register
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_val <= '0;
		end else begin
			pin_val <= pin_i;
		end
	end

endmodule : port_bank

// [hw/legacy_compat.sv]
// Legacy compatibility fuse handling, port reset behaviour and APB registers.
// Assumes an APB master on pclk and a reset pin that may arrive without a clock.
//
// Behaviour
// - Fuse set: extended I/O becomes plain RAM.
// - Fuse set: watchdog period needs no unlock.
// - Fuse set: receiver keeps one byte only.
// - Fuse set: no pin-change requests at all.
// - Fuse set: second 16-bit timer unreachable.
// - Two baud-high registers, fixed addresses always.
// - Reset tri-states all port pins instantly.
// - Each port bit has own pull-up.
// - JTAG enabled: test pin pull-ups stay on.
// - Low reset pin resets without clock.
// - Extended I/O spans 0x60 to 0xFF.
// - Fuse set: extended vectors are removed.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module legacy_compat (
	// Clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_pin_n,
	// Fuses
	input wire logic legacy_compat_fuse,
	input wire logic jtag_enable,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core data-space decode
	input wire logic [15:0] core_addr,
	input wire logic core_valid,
	output logic ext_io_sel,
	output logic ram_sel,
	output logic timer2_sel,
	// Interrupt vectors
	input wire logic [compat_pkg::VEC_EXTENDED-1:0] irq_req,
	output logic vec_valid,
	output logic [compat_pkg::VEC_W-1:0] vec_num,
	// Serial receiver and baud
	input compat_pkg::rx_byte_t rx_in,
	output logic [3:0] serial0_baud_high,
	output logic [3:0] serial1_baud_high,
	// Watchdog and pin change
	output logic [2:0] wdt_period,
	output logic pin_change_req,
	// Feature set
	output compat_pkg::feature_t features,
	// Port pads
	input compat_pkg::pins_t pin_i,
	output compat_pkg::pins_t pin_o,
	output compat_pkg::pins_t pin_oe,
	output compat_pkg::pins_t pull_en
);

	// Address range checks
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_range

	// Width of a port by index
	function automatic int port_width(input int p);
		return (p == compat_pkg::NUM_PORTS - 1) ? compat_pkg::PORT_E_W : compat_pkg::PORT_MAX_W;
	endfunction : port_width

	logic rst_n;
	logic armed_reg;
	logic compat_reg;
	logic compat_now;
	logic [4:0][7:0] dir_reg;
	logic [4:0][7:0] out_reg;
	logic [4:0][7:0] in_val;
	logic [7:0] pc_mask_reg;
	logic [7:0] pc_prev_reg;
	logic [2:0] wdt_period_reg;
	logic [2:0] unlock_cnt_reg;
	logic [3:0] baud0_reg;
	logic [3:0] baud1_reg;
	logic [7:0] rx_head_reg;
	logic [7:0] rx_tail_reg;
	logic [1:0] rx_count_reg;
	logic rx_overrun_reg;
	logic [31:0] prdata_reg;
	logic wr_en;
	logic rd_en;
	logic setup;
	logic port_hit;
	logic [2:0] port_idx;
	logic [3:0] port_ofs;
	logic mapped;
	logic rx_pop;
	logic [1:0] rx_depth;

	// Reset pin and bus reset both act at once
	assign rst_n = presetn & reset_pin_n;

	// Fuse captured on the first edge after reset release
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			armed_reg <= 1'b0;
			compat_reg <= 1'b0;
		end else if (!armed_reg) begin
			armed_reg <= 1'b1;
			compat_reg <= legacy_compat_fuse;
		end
	end

	// Feature set derived from the held fuse state
	always_comb begin
		features.ext_io = ~compat_reg;
		features.wdt_timed = ~compat_reg;
		features.rx_double = ~compat_reg;
		features.pin_change = ~compat_reg;
		features.timer2 = ~compat_reg;
		features.ext_vectors = ~compat_reg;
	end

	// Data-space routing of the extended I/O window
	always_comb begin
		ext_io_sel = core_valid & ~compat_reg
			& in_range(core_addr, compat_pkg::EXT_IO_LO, compat_pkg::EXT_IO_HI);
		ram_sel = core_valid & ~ext_io_sel;
		timer2_sel = ext_io_sel
			& in_range(core_addr, compat_pkg::TIMER2_LO, compat_pkg::TIMER2_HI);
	end

	// Fuse level on the latching edge, held copy afterwards
	assign compat_now = armed_reg ? compat_reg : legacy_compat_fuse;

	// Vector arbitration, lowest number first, legacy table only in compat
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			vec_valid <= 1'b0;
			vec_num <= '0;
		end else begin
			vec_valid <= 1'b0;
			vec_num <= '0;
			for (int i = compat_pkg::VEC_EXTENDED - 1; i >= 0; i--) begin
				if (irq_req[i] && (!compat_now || i < compat_pkg::VEC_LEGACY)) begin
					vec_valid <= 1'b1;
					vec_num <= i[compat_pkg::VEC_W-1:0];
				end
			end
		end
	end

	// APB decode
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign port_hit = (paddr >= compat_pkg::ADDR_PORT_BASE) && (paddr <= compat_pkg::ADDR_PORT_END);
	assign port_idx = paddr[6:4] - 3'd2;
	assign port_ofs = paddr[3:0];
	assign pready = 1'b1;

	always_comb begin
		case (paddr)
			compat_pkg::ADDR_STATUS, compat_pkg::ADDR_WDT, compat_pkg::ADDR_BAUD0,
			compat_pkg::ADDR_BAUD1, compat_pkg::ADDR_RX_DATA, compat_pkg::ADDR_RX_STAT,
			compat_pkg::ADDR_PC_MASK: mapped = 1'b1;
			default: mapped = port_hit && (port_ofs == compat_pkg::PORT_DIR_OFS
				|| port_ofs == compat_pkg::PORT_OUT_OFS || port_ofs == compat_pkg::PORT_IN_OFS);
		endcase
	end
	assign pslverr = psel & penable & ~mapped;

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= '0;
		end else if (setup) begin
			prdata_reg <= '0;
			case (paddr)
				compat_pkg::ADDR_STATUS: prdata_reg <= {26'h0, features};
				compat_pkg::ADDR_WDT: prdata_reg <= {27'h0, (unlock_cnt_reg != 3'h0),
					1'b0, wdt_period_reg};
				compat_pkg::ADDR_BAUD0: prdata_reg <= {28'h0, baud0_reg};
				compat_pkg::ADDR_BAUD1: prdata_reg <= {28'h0, baud1_reg};
				compat_pkg::ADDR_RX_DATA: prdata_reg <= {24'h0, rx_head_reg};
				compat_pkg::ADDR_RX_STAT: prdata_reg <= {29'h0, rx_overrun_reg,
					(rx_count_reg == rx_depth), (rx_count_reg != 2'd0)};
				compat_pkg::ADDR_PC_MASK: prdata_reg <= {24'h0, pc_mask_reg & {8{~compat_reg}}};
				default: begin
					if (port_hit && port_ofs == compat_pkg::PORT_DIR_OFS)
						prdata_reg <= {24'h0, dir_reg[port_idx]};
					else if (port_hit && port_ofs == compat_pkg::PORT_OUT_OFS)
						prdata_reg <= {24'h0, out_reg[port_idx]};
					else if (port_hit && port_ofs == compat_pkg::PORT_IN_OFS)
						prdata_reg <= {24'h0, in_val[port_idx]};
				end
			endcase
		end
	end
	assign prdata = prdata_reg;

	// Port direction and output registers, cleared asynchronously
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			dir_reg <= '0;
			out_reg <= '0;
		end else if (wr_en && port_hit) begin
			if (port_ofs == compat_pkg::PORT_DIR_OFS)
				dir_reg[port_idx] <= pwdata[7:0];
			else if (port_ofs == compat_pkg::PORT_OUT_OFS)
				out_reg[port_idx] <= pwdata[7:0];
		end
	end

	// Port pad banks
	for (genvar g = 0; g < compat_pkg::NUM_PORTS; g++) begin : g_port
		localparam int W = port_width(g);
		localparam int B = g * compat_pkg::PORT_MAX_W;
		logic [W-1:0] force_pull;
		logic [W-1:0] val;
		// Test pins keep pull-ups while the debug port is enabled
		assign force_pull = (g == compat_pkg::JTAG_PORT) ?
			compat_pkg::JTAG_PULL_MASK[W-1:0] & {W{jtag_enable}} : '0;
		port_bank #(.W(W)) u_bank (
			.pclk(pclk),
			.rst_n(rst_n),
			.dir(dir_reg[g][W-1:0]),
			.out(out_reg[g][W-1:0]),
			.pull_force(force_pull),
			.pin_i(pin_i[B+W-1:B]),
			.pin_o(pin_o[B+W-1:B]),
			.pin_oe(pin_oe[B+W-1:B]),
			.pull_en(pull_en[B+W-1:B]),
			.pin_val(val)
		);
		if (W < compat_pkg::PORT_MAX_W) begin : g_pad
			assign in_val[g] = {{(compat_pkg::PORT_MAX_W - W){1'b0}}, val};
		end else begin : g_full
			assign in_val[g] = val;
		end
	end

	// Baud high bytes, one per channel, map unchanged by the fuse
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			baud0_reg <= compat_pkg::BAUD_HIGH_RST;
			baud1_reg <= compat_pkg::BAUD_HIGH_RST;
		end else if (wr_en) begin
			if (paddr == compat_pkg::ADDR_BAUD0)
				baud0_reg <= pwdata[3:0];
			if (paddr == compat_pkg::ADDR_BAUD1)
				baud1_reg <= pwdata[3:0];
		end
	end
	assign serial0_baud_high = baud0_reg;
	assign serial1_baud_high = baud1_reg;

	// Watchdog period with timed change window in native mode
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_period_reg <= compat_pkg::WDT_PERIOD_RST;
			unlock_cnt_reg <= '0;
		end else begin
			if (unlock_cnt_reg != 3'h0)
				unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
			if (wr_en && paddr == compat_pkg::ADDR_WDT) begin
				if (compat_reg) begin
					wdt_period_reg <= pwdata[2:0];
				end else if (pwdata[compat_pkg::WDT_CHANGE_BIT]) begin
					unlock_cnt_reg <= 3'(compat_pkg::WDT_UNLOCK_CYCLES);
				end else if (unlock_cnt_reg != 3'h0) begin
					wdt_period_reg <= pwdata[2:0];
					unlock_cnt_reg <= '0;
				end
			end
		end
	end
	assign wdt_period = wdt_period_reg;

	// Receive holding: two bytes native, one byte in compat
	assign rx_depth = compat_reg ? 2'd1 : 2'd2;
	assign rx_pop = rd_en && paddr == compat_pkg::ADDR_RX_DATA && rx_count_reg != 2'd0;

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_head_reg <= '0;
			rx_tail_reg <= '0;
			rx_count_reg <= '0;
			rx_overrun_reg <= 1'b0;
		end else begin
			if (rx_pop && paddr == compat_pkg::ADDR_RX_DATA)
				rx_overrun_reg <= 1'b0;
			if (rx_pop) begin
				rx_head_reg <= rx_tail_reg;
				rx_count_reg <= rx_count_reg - 2'd1;
			end
			if (rx_in.valid) begin
				if (rx_count_reg == rx_depth && !rx_pop) begin
					rx_overrun_reg <= 1'b1;
				end else begin
					if (rx_count_reg == 2'd0 || (rx_pop && rx_count_reg == 2'd1))
						rx_head_reg <= rx_in.data;
					else
						rx_tail_reg <= rx_in.data;
					rx_count_reg <= rx_pop ? rx_count_reg : rx_count_reg + 2'd1;
				end
			end
		end
	end

	// Pin-change mask, writes ignored in compat
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_mask_reg <= '0;
		end else if (wr_en && paddr == compat_pkg::ADDR_PC_MASK && !compat_reg) begin
			pc_mask_reg <= pwdata[7:0];
		end
	end

	// Pin-change detection on the first port
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_prev_reg <= '0;
			pin_change_req <= 1'b0;
		end else begin
			pc_prev_reg <= in_val[0];
			pin_change_req <= ~compat_reg & (|((in_val[0] ^ pc_prev_reg) & pc_mask_reg));
		end
	end

endmodule : legacy_compat

// [tb/legacy_compat_chk.sv]
// Checker for legacy_compat: decode, reset pads, fuse hold, vectors, registers.
// Assumes it is bound to legacy_compat and sees only that module's ports.
`timescale 1ns/10ps
module legacy_compat_chk (
	// Clock, resets and JTAG enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_pin_n,
	input wire logic jtag_enable,
	// Bus writes
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Decode and vectors
	input wire logic [15:0] core_addr,
	input wire logic core_valid,
	input wire logic ext_io_sel,
	input wire logic timer2_sel,
	input wire logic [compat_pkg::VEC_EXTENDED-1:0] irq_req,
	input wire logic vec_valid,
	input wire logic [compat_pkg::VEC_W-1:0] vec_num,
	// Registers and pads
	input wire logic [3:0] serial0_baud_high,
	input wire logic [2:0] wdt_period,
	input wire logic pin_change_req,
	input compat_pkg::feature_t features,
	input compat_pkg::pins_t pin_oe,
	input compat_pkg::pins_t pull_en
);
	// Write strobe, narrowed data, range decode
	wire wr = psel && penable && pwrite;
	wire [2:0] wd = pwdata[2:0];
	wire [3:0] bd = pwdata[3:0];
	wire in_ext = core_addr >= 16'h0060 && core_addr <= 16'h00FF;
	default clocking @(posedge pclk); endclocking
	default disable iff (!(presetn && reset_pin_n));
	a_reset_tristate: assert property (disable iff (!presetn) !reset_pin_n |-> pin_oe == '0)
		else $error("pads driven in reset");
	a_jtag_pullup: assert property (disable iff (!presetn)
		jtag_enable |-> pull_en[23] && pull_en[21] && pull_en[20]) else $error("jtag pull off");
	a_ext_decode: assert property (ext_io_sel == (core_valid && features.ext_io && in_ext))
		else $error("ext decode");
	a_timer2_gate: assert property (timer2_sel == (ext_io_sel && core_addr inside {[16'h0080:16'h008B]}))
		else $error("timer2 decode");
	a_pc_silent: assert property (!features.pin_change |-> !pin_change_req)
		else $error("pin change in compat");
	a_fuse_held: assert property (1'b1 [*3] |=> $stable(features))
		else $error("features moved");
	a_vec_legacy: assert property (vec_valid && !features.ext_vectors |-> vec_num < 5'h14)
		else $error("extended vector");
	a_vec_first: assert property (irq_req[0] |=> vec_valid && vec_num == '0)
		else $error("vector zero lost");
	a_wdt_direct: assert property (wr && paddr == compat_pkg::ADDR_WDT && !features.wdt_timed
		|=> wdt_period == $past(wd)) else $error("wdt write lost");
	a_baud_write: assert property (wr && paddr == compat_pkg::ADDR_BAUD0
		|=> serial0_baud_high == $past(bd)) else $error("baud write lost");
	// Main scenarios
	c_compat: cover property (!features.ext_io && wr);
	c_pc: cover property (pin_change_req);
	c_t2: cover property (timer2_sel);
endmodule : legacy_compat_chk

bind legacy_compat legacy_compat_chk u_chk (.pclk, .presetn, .reset_pin_n, .jtag_enable, .psel,
	.penable, .pwrite, .paddr, .pwdata, .core_addr, .core_valid, .ext_io_sel, .timer2_sel,
	.irq_req, .vec_valid, .vec_num, .serial0_baud_high, .wdt_period, .pin_change_req,
	.features, .pin_oe, .pull_en);

// [tb/board_model.sv]
// Board model: resolves the port pads and drives the external reset pin.
// Assumes pad controls from the device and drive requests from the bench.
`timescale 1ns/10ps
module board_model (
	// Clock
	input wire logic pclk,
	// Device pad controls
	input compat_pkg::pins_t pin_o,
	input compat_pkg::pins_t pin_oe,
	input compat_pkg::pins_t pull_en,
	// Board drive
	input compat_pkg::pins_t ext_val,
	input compat_pkg::pins_t ext_drv,
	input wire logic rst_req,
	// Pads and reset pin
	output compat_pkg::pins_t pin_i,
	output logic reset_pin_n
);
	compat_pkg::pins_t noise = '0;
	// Floating pads wander every cycle
	always @(posedge pclk) noise <= ~noise;
	// Device drive, then board, then pull-up
	always_comb
		for (int i = 0; i < compat_pkg::PIN_COUNT; i++)
			pin_i[i] = pin_oe[i] ? pin_o[i] : ext_drv[i] ? ext_val[i] : pull_en[i] | noise[i];
	// Low pulse of the minimum length, clock or not
	initial begin
		reset_pin_n = 1'b1;
		forever begin
			@(posedge rst_req);
			reset_pin_n = 1'b0;
			#(compat_pkg::RESET_MIN_PULSE_NS);
			reset_pin_n = 1'b1;
		end
	end
endmodule : board_model

// [tb/legacy_compat_tb.sv]
// Self-checking bench for legacy_compat in native and compatibility modes.
// Assumes the board model drives pads and reset pin; checker is bound.
`timescale 1ns/10ps
module legacy_compat_tb;
	logic pclk = 0, presetn = 0, clk_run = 1, rst_req = 0, core_valid = 0, err;
	logic legacy_compat_fuse = 0, jtag_enable = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, b, prdata;
	logic [15:0] core_addr = '0;
	logic [27:0] irq_req = '0;
	compat_pkg::rx_byte_t rx_in = '0;
	compat_pkg::pins_t ext_val = '0, ext_drv = '0, pin_i, pin_o, pin_oe, pull_en;
	logic pready, pslverr, ext_io_sel, ram_sel, timer2_sel, vec_valid, pin_change_req, reset_pin_n;
	logic [4:0] vec_num;
	logic [3:0] serial0_baud_high, serial1_baud_high;
	logic [2:0] wdt_period;
	compat_pkg::feature_t features;
	int seed = 57307, error_cnt = 0, comparisons = 0;
	logic [7:0] q[$];
	legacy_compat dut (.pclk, .presetn, .reset_pin_n, .legacy_compat_fuse, .jtag_enable,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_addr,
		.core_valid, .ext_io_sel, .ram_sel, .timer2_sel, .irq_req, .vec_valid, .vec_num,
		.rx_in, .serial0_baud_high, .serial1_baud_high, .wdt_period, .pin_change_req,
		.features, .pin_i, .pin_o, .pin_oe, .pull_en);
	board_model board (.pclk, .pin_o, .pin_oe, .pull_en, .ext_val, .ext_drv, .rst_req,
		.pin_i, .reset_pin_n);
	// Clock, stoppable for the clockless reset
	initial forever #2 if (clk_run) pclk = ~pclk;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask : rdc
	function automatic logic [11:0] pa(input int n, input logic [3:0] o);
		return compat_pkg::ADDR_PORT_BASE + 12'(16 * n) + {8'h0, o};
	endfunction : pa
	task automatic pc(input logic e);
		ext_drv[0] <= 1'b1;
		ext_val[0] <= ~pin_i[0];
		repeat (2) @(posedge pclk);
		#1;
		chk("pc pulse", {31'h0, e}, {31'h0, pin_change_req});
		@(posedge pclk);
		#1;
		chk("pc end", 32'h0, {31'h0, pin_change_req});
		@(posedge pclk);
	endtask : pc
	task automatic rx2(input logic [15:0] v, input int cap);
		logic ov;
		ov = 1'b0;
		q = {};
		for (int i = 0; i < 2; i++) begin
			rx_in <= {1'b1, v[8*i +: 8]};
			@(posedge pclk);
			if (q.size() < cap) q.push_back(v[8*i +: 8]);
			else ov = 1'b1;
		end
		rx_in <= '0;
		@(posedge pclk);
		rdc("rx stat", compat_pkg::ADDR_RX_STAT, {29'h0, ov, q.size() == cap, q.size() > 0});
		rdc("rx data", compat_pkg::ADDR_RX_DATA, {24'h0, q.pop_front()});
		rdc("rx stat2", compat_pkg::ADDR_RX_STAT, {30'h0, q.size() == cap, q.size() > 0});
	endtask : rx2
	task automatic dc(input logic c);
		logic x;
		logic [15:0] al[5] = '{16'h005F, 16'h0060, 16'h0085, 16'h00FF, 16'h0100};
		foreach (al[i]) begin
			core_valid <= 1'b1;
			core_addr <= al[i];
			#1;
			x = !c && al[i] >= 16'h0060 && al[i] <= 16'h00FF;
			chk("decode", {29'h0, x, !x, x && al[i] >= 16'h0080 && al[i] <= 16'h008B},
				{29'h0, ext_io_sel, ram_sel, timer2_sel});
			@(posedge pclk);
		end
		core_valid <= 1'b0;
	endtask : dc
	task automatic vc(input logic [27:0] r, input int lim);
		int e;
		e = -1;
		for (int i = lim - 1; i >= 0; i--) if (r[i]) e = i;
		irq_req <= r;
		repeat (2) @(posedge pclk);
		#1;
		chk("vec", e < 0 ? 32'h0 : 32'h20 | e, vec_valid ? 32'h20 | vec_num : 32'h0);
		@(posedge pclk);
	endtask : vc
	task automatic close_out();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdc("status", compat_pkg::ADDR_STATUS, 32'h3F);
		b = $random(seed);
		apb(1'b1, compat_pkg::ADDR_BAUD0, b);
		apb(1'b1, compat_pkg::ADDR_BAUD1, ~b);
		rdc("baud1", compat_pkg::ADDR_BAUD1, {28'h0, ~b[3:0]});
		apb(1'b1, compat_pkg::ADDR_WDT, 32'h5);
		rdc("wdt lock", compat_pkg::ADDR_WDT, 32'h0);
		apb(1'b1, compat_pkg::ADDR_WDT, 32'h10);
		apb(1'b1, compat_pkg::ADDR_WDT, 32'h5);
		rdc("wdt open", compat_pkg::ADDR_WDT, 32'h5);
		apb(1'b0, 12'hFFC, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, pa(0, 4'h4), 32'hFF);
		apb(1'b1, pa(1, 4'h0), 32'hFF);
		apb(1'b1, pa(1, 4'h4), b);
		apb(1'b1, pa(2, 4'h4), b >> 8);
		chk("drive", {16'h0, 8'hFF, b[7:0]}, {16'h0, pin_oe[15:8], pin_o[15:8]});
		chk("pulls", {24'h0, b[15:8] | 8'hB0}, {24'h0, pull_en[23:16]});
		apb(1'b1, compat_pkg::ADDR_PC_MASK, 32'h1);
		pc(1'b1);
		rx2(b[31:16], 2);
		dc(1'b0);
		repeat (4) vc(28'($random(seed)), compat_pkg::VEC_EXTENDED);
		$display("test native done");
		@(posedge pclk);
		clk_run = 1'b0;
		rst_req <= 1'b1;
		legacy_compat_fuse <= 1'b1;
		#10;
		chk("oe reset", 32'h0, {31'h0, |pin_oe});
		chk("jtag pull", 32'h7, {29'h0, pull_en[23], pull_en[21], pull_en[20]});
		// Clock resumes while the pin is still low, release lands on a falling edge
		#1;
		clk_run = 1'b1;
		wait (reset_pin_n);
		@(posedge pclk);
		rst_req <= 1'b0;
		repeat (2) @(posedge pclk);
		$display("test reset done");
		rdc("status c", compat_pkg::ADDR_STATUS, 32'h0);
		apb(1'b1, compat_pkg::ADDR_WDT, 32'h5);
		rdc("wdt free", compat_pkg::ADDR_WDT, 32'h5);
		apb(1'b1, compat_pkg::ADDR_BAUD0, b);
		rdc("baud0", compat_pkg::ADDR_BAUD0, {28'h0, b[3:0]});
		apb(1'b1, compat_pkg::ADDR_PC_MASK, 32'h1);
		rdc("pc mask", compat_pkg::ADDR_PC_MASK, 32'h0);
		pc(1'b0);
		rx2(b[15:0], 1);
		dc(1'b1);
		vc(28'h0880000, compat_pkg::VEC_LEGACY);
		vc(28'h0800000, compat_pkg::VEC_LEGACY);
		legacy_compat_fuse <= 1'b0;
		rdc("status held", compat_pkg::ADDR_STATUS, 32'h0);
		$display("test compat done");
		close_out();
	end
	// Hang guard
	initial begin
		#200000;
		error_cnt++;
		close_out();
	end
endmodule : legacy_compat_tb
